//--- hw/adcgdc_pkg.sv
// shared constants and types of the general and data configuration bank
package adcgdc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_GENERAL = 8'h01;
  localparam logic [7:0] ADDR_DATA = 8'h02;
  localparam logic [7:0] GENERAL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic BROWNOUT_RESET = 1'b1;
  // writable bits; reserved and write-only bits never store
  localparam logic [7:0] GENERAL_WMASK = 8'h76;
  localparam logic [7:0] DATA_WMASK = 8'hb3;
  // status bit 7 always reads one
  localparam logic [7:0] STATUS_FIXED = 8'h80;
  localparam int STATUS_CHKERR_BIT = 1;
  localparam int STATUS_BROWN_BIT = 0;
  localparam int GENERAL_SOFTRST_BIT = 0;
  localparam int GENERAL_CAL_BIT = 1;

  // ------------------------------------------------------------
  // serial frame
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h10;
  localparam logic [7:0] OP_WRITE = 8'h08;
  localparam logic [5:0] FRAME_BITS = 6'h18;
  localparam logic [5:0] FRAME_CHK_BITS = 6'h20;
  localparam logic [7:0] CHK_POLY = 8'h07;

  // ------------------------------------------------------------
  // data path and statistics
  // ------------------------------------------------------------
  localparam logic [11:0] FIX_CODE = 12'ha5a;
  localparam logic [11:0] STAT_MIN_CLEAR = 12'hfff;
  localparam logic [11:0] STAT_MAX_CLEAR = 12'h000;
  localparam logic [11:0] STAT_RECENT_CLEAR = 12'h000;

  typedef enum logic [1:0] {
    TAG_NONE = 2'h0,
    TAG_CHANNEL = 2'h1,
    TAG_STATUS = 2'h2,
    TAG_RESERVED = 2'h3
  } adcgdc_tag_t;

  typedef struct packed {
    logic rsv7;
    logic crcEnable;
    logic statisticsEnable;
    logic windowComparatorEnable;
    logic rsv3;
    logic forceAnalogChannels;
    logic calibrate;
    logic softReset;
  } adcgdc_general_t;

  typedef struct packed {
    logic fixedPatternOutput;
    logic rsv6;
    logic [1:0] tagSelect;
    logic [1:0] rsv32;
    logic [1:0] serialClockFormat;
  } adcgdc_data_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic [31:0] shift;
  } adcgdc_edge_t;

  // check code over 24 bits, msb first
  function automatic logic [7:0] chk8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CHK_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

//--- hw/adcgdc_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module adcgdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- hw/adcgdc_link.sv
// serial-clock side: shifts frames in and the answer word out
`timescale 1ns/1ns
module adcgdc_link (
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [1:0] clockFormat,
  input wire logic [31:0] resp,
  output logic miso,
  output logic misoOe,
  output logic [31:0] linkWord,
  output logic [5:0] linkCount
);
  logic [1:0] fmt;
  logic pStarted;
  logic nStarted;
  logic samplePos;
  logic [5:0] launchCnt;
  logic [5:0] bitSel;
  adcgdc_pkg::adcgdc_edge_t p;
  adcgdc_pkg::adcgdc_edge_t n;
  adcgdc_pkg::adcgdc_edge_t next_p;
  adcgdc_pkg::adcgdc_edge_t next_n;

  // format changes only take hold after two rising serial clock edges
  adcgdc_sync #(.WIDTH(2)) fmtSync (
    .clk(sclk),
    .rst(rst),
    .d(clockFormat),
    .q(fmt)
  );

  function automatic adcgdc_pkg::adcgdc_edge_t edge_next(
    input adcgdc_pkg::adcgdc_edge_t e,
    input logic started,
    input logic bitIn
  );
    adcgdc_pkg::adcgdc_edge_t r;
    r.cnt = (e.cnt == 6'h3f) ? e.cnt : e.cnt + 6'h01;
    r.shift = {e.shift[30:0], bitIn};
    if (!started) begin
      r.cnt = 6'h01;
      r.shift = {31'h0, bitIn};
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // both edges capture; the format picks which one counts
  // ------------------------------------------------------------
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      pStarted <= 1'b0;
    end else begin
      pStarted <= 1'b1;
    end
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      nStarted <= 1'b0;
    end else begin
      nStarted <= 1'b1;
    end
  end

  always_comb begin
    next_p = edge_next(p, pStarted, mosi);
    next_n = edge_next(n, nStarted, mosi);
  end

  // frame contents are kept after the frame so the core can read them
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      n <= '0;
    end else begin
      n <= next_n;
    end
  end

  // ------------------------------------------------------------
  // polarity and phase
  // ------------------------------------------------------------
  always_comb begin
    samplePos = (fmt[1] == fmt[0]);
    launchCnt = 6'h00;
    if (samplePos && nStarted) begin
      launchCnt = n.cnt;
    end else if (!samplePos && pStarted) begin
      launchCnt = p.cnt;
    end
    // phase one launches each bit on the first edge of its pair
    bitSel = fmt[0] ? launchCnt - 6'h01 : launchCnt;
    miso = 1'b0;
    if (bitSel < 6'h20) begin
      miso = resp[5'(6'h1f - bitSel)];
    end
    misoOe = ~csN;
    linkWord = samplePos ? p.shift : n.shift;
    linkCount = samplePos ? p.cnt : n.cnt;
  end
endmodule

//--- hw/adcgdc_top.sv
// general and data output configuration bank with its serial port
//
// Operation
// - check-code enable appends codes to answers and checks incoming frames.
// - statistics enable clears min, max and recent, then updates them.
// - with statistics disabled, min, max and recent hold their values until a soft reset clears them.
// - window comparator enable runs it; zero disables and resets it.
// - force-analog makes every channel analog, whatever other config says.
// - calibration bit starts offset calibration; calDone clears it, except in a cycle with a non-reset write to address 1.
// - soft reset restores defaults, reads zero, sets the brownout flag.
// - reserved bits ignore writes and read zero.
// - fixed pattern makes every data read return code a5a.
// - tag select appends nothing, channel id, or status flags.
// - clock format picks serial polarity and phase; host must match.
// - on input check error only addresses 0 and 1 accept writes.
// - brownout flag lives in status; host writes one to clear it.
`timescale 1ns/1ns
module adcgdc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic convValid,
  input wire logic [11:0] convData,
  input wire logic [3:0] convChannel,
  input wire logic [3:0] convFlags,
  input wire logic calDone,
  input wire logic [7:0] pinGpioConfig,
  output logic miso,
  output logic misoOe,
  output logic checkEnable,
  output logic windowCompEnable,
  output logic [7:0] channelIsGpio,
  output logic calStart,
  output logic softResetPulse,
  output logic [11:0] statMin,
  output logic [11:0] statMax,
  output logic [11:0] statRecent,
  output logic [15:0] dataOut,
  output logic dataValid
);
  typedef struct packed {
    adcgdc_pkg::adcgdc_general_t gen;
    adcgdc_pkg::adcgdc_data_t dcfg;
    logic checkErr;
    logic brownout;
    logic calStart;
    logic softResetPulse;
    logic csPrev;
    logic [31:0] resp;
    logic [11:0] statMin;
    logic [11:0] statMax;
    logic [11:0] statRecent;
    logic [7:0] gpioMask;
    logic [15:0] dataOut;
    logic dataValid;
  } adcgdc_top_state_t;

  localparam adcgdc_top_state_t ST_RESET = '{
    gen: adcgdc_pkg::GENERAL_RESET,
    dcfg: adcgdc_pkg::DATA_RESET,
    brownout: adcgdc_pkg::BROWNOUT_RESET,
    statMin: adcgdc_pkg::STAT_MIN_CLEAR,
    default: '0
  };

  adcgdc_top_state_t s;
  adcgdc_top_state_t next_s;
  logic csSel;
  logic [31:0] linkWord;
  logic [5:0] linkCount;
  logic frameEnd;
  logic frameOk;
  logic checkPass;
  logic [7:0] frOp;
  logic [7:0] frAddr;
  logic [7:0] frData;
  logic isWrite;
  logic isRead;
  logic writeAllowed;
  logic [7:0] rdByte;
  logic [3:0] tagNibble;

  // ------------------------------------------------------------
  // serial side and frame-end crossing
  // ------------------------------------------------------------
  adcgdc_link link (
    .rst(rst),
    .sclk(sclk),
    .csN(csN),
    .mosi(mosi),
    .clockFormat(s.dcfg.serialClockFormat),
    .resp(s.resp),
    .miso(miso),
    .misoOe(misoOe),
    .linkWord(linkWord),
    .linkCount(linkCount)
  );

  // synced select idles low like its reset value, so no false frame end
  // follows reset; the word is still once the select has dropped here
  adcgdc_sync #(.WIDTH(1)) csSync (
    .clk(clk),
    .rst(rst),
    .d(~csN),
    .q(csSel)
  );

  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  always_comb begin
    frameEnd = !csSel && s.csPrev;
    if (s.gen.crcEnable) begin
      frameOk = (linkCount == adcgdc_pkg::FRAME_CHK_BITS);
      frOp = linkWord[31:24];
      frAddr = linkWord[23:16];
      frData = linkWord[15:8];
      checkPass = (linkWord[7:0] == adcgdc_pkg::chk8(linkWord[31:8]));
    end else begin
      frameOk = (linkCount == adcgdc_pkg::FRAME_BITS);
      frOp = linkWord[23:16];
      frAddr = linkWord[15:8];
      frData = linkWord[7:0];
      checkPass = 1'b1;
    end
    isWrite = frameEnd && frameOk && checkPass &&
      (frOp == adcgdc_pkg::OP_WRITE);
    isRead = frameEnd && frameOk && checkPass &&
      (frOp == adcgdc_pkg::OP_READ);
    writeAllowed = !s.checkErr ||
      (frAddr == adcgdc_pkg::ADDR_STATUS) ||
      (frAddr == adcgdc_pkg::ADDR_GENERAL);
    if (frAddr == adcgdc_pkg::ADDR_STATUS) begin
      rdByte = adcgdc_pkg::STATUS_FIXED |
        {6'h00, s.checkErr, s.brownout};
    end else if (frAddr == adcgdc_pkg::ADDR_GENERAL) begin
      rdByte = s.gen;
    end else if (frAddr == adcgdc_pkg::ADDR_DATA) begin
      rdByte = s.dcfg;
    end else begin
      rdByte = 8'h00;
    end
    case (s.dcfg.tagSelect)
      adcgdc_pkg::TAG_CHANNEL: tagNibble = convChannel;
      adcgdc_pkg::TAG_STATUS: tagNibble = convFlags;
      default: tagNibble = 4'h0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.calStart = 1'b0;
    next_s.softResetPulse = 1'b0;
    next_s.dataValid = 1'b0;
    next_s.csPrev = csSel;
    if (calDone) begin
      next_s.gen.calibrate = 1'b0;
    end
    next_s.gpioMask = s.gen.forceAnalogChannels ? 8'h00 : pinGpioConfig;
    if (convValid) begin
      next_s.dataValid = 1'b1;
      next_s.dataOut = {s.dcfg.fixedPatternOutput ?
        adcgdc_pkg::FIX_CODE : convData, tagNibble};
    end
    if (s.gen.statisticsEnable && convValid) begin
      next_s.statRecent = convData;
      if (convData < s.statMin) begin
        next_s.statMin = convData;
      end
      if (convData > s.statMax) begin
        next_s.statMax = convData;
      end
    end
    if (frameEnd && frameOk && !checkPass) begin
      next_s.checkErr = 1'b1;
    end
    if (isWrite && writeAllowed) begin
      if (frAddr == adcgdc_pkg::ADDR_STATUS) begin
        if (frData[adcgdc_pkg::STATUS_CHKERR_BIT]) begin
          next_s.checkErr = 1'b0;
        end
        if (frData[adcgdc_pkg::STATUS_BROWN_BIT]) begin
          next_s.brownout = 1'b0;
        end
      end else if (frAddr == adcgdc_pkg::ADDR_GENERAL) begin
        if (frData[adcgdc_pkg::GENERAL_SOFTRST_BIT]) begin
          next_s = ST_RESET;
          next_s.softResetPulse = 1'b1;
          next_s.csPrev = csSel;
        end else begin
          next_s.gen = frData & adcgdc_pkg::GENERAL_WMASK;
          // only the converter or a soft reset may end a calibration in progress
          next_s.gen.calibrate = s.gen.calibrate ||
            frData[adcgdc_pkg::GENERAL_CAL_BIT];
          next_s.calStart = frData[adcgdc_pkg::GENERAL_CAL_BIT] &&
            !s.gen.calibrate;
        end
      end else if (frAddr == adcgdc_pkg::ADDR_DATA) begin
        next_s.dcfg = frData & adcgdc_pkg::DATA_WMASK;
      end
    end
    if (isRead) begin
      if (s.gen.crcEnable) begin
        next_s.resp = {rdByte, adcgdc_pkg::chk8({8'h00, frAddr, rdByte}),
          16'h0000};
      end else begin
        next_s.resp = {rdByte, 24'h000000};
      end
    end
    if (next_s.gen.statisticsEnable && !s.gen.statisticsEnable) begin
      next_s.statMin = adcgdc_pkg::STAT_MIN_CLEAR;
      next_s.statMax = adcgdc_pkg::STAT_MAX_CLEAR;
      next_s.statRecent = adcgdc_pkg::STAT_RECENT_CLEAR;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign checkEnable = s.gen.crcEnable;
  assign windowCompEnable = s.gen.windowComparatorEnable;
  assign channelIsGpio = s.gpioMask;
  assign calStart = s.calStart;
  assign softResetPulse = s.softResetPulse;
  assign statMin = s.statMin;
  assign statMax = s.statMax;
  assign statRecent = s.statRecent;
  assign dataOut = s.dataOut;
  assign dataValid = s.dataValid;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  badCheck_sets_a: assert property (
    frameEnd && frameOk && !checkPass |=> s.checkErr)
    else $error("bad check code did not raise the error flag");
  statsClear_a: assert property (
    $rose(s.gen.statisticsEnable) |-> s.statMax == 12'h000 &&
      s.statRecent == 12'h000 && s.statMin == 12'hfff)
    else $error("statistics not cleared on enable");
  statsHold_a: assert property (
    !s.gen.statisticsEnable ##1 !s.gen.statisticsEnable |->
      softResetPulse || ($stable(s.statRecent) && $stable(s.statMin) &&
      $stable(s.statMax)))
    else $error("statistics moved while disabled");
  windowOff_a: assert property (
    isWrite && frAddr == 8'h01 && !frData[0] && !frData[4] |=>
      !windowCompEnable)
    else $error("window comparator still enabled after zero write");
  forceAnalog_a: assert property (
    s.gen.forceAnalogChannels |=> channelIsGpio == 8'h00)
    else $error("gpio channel left while analog forced");
  calDone_a: assert property (
    calDone && !isWrite |=> !s.gen.calibrate)
    else $error("calibration bit not cleared on completion");
  softReset_a: assert property (
    isWrite && frAddr == 8'h01 && frData[0] |=>
      s.brownout && s.gen == 8'h00 && s.dcfg == 8'h00 && softResetPulse
      ##1 !softResetPulse)
    else $error("soft reset did not restore defaults");
  reservedZero_a: assert property (
    s.gen.rsv7 == 1'b0 && s.gen.rsv3 == 1'b0 && s.gen.softReset == 1'b0 &&
      s.dcfg.rsv6 == 1'b0 && s.dcfg.rsv32 == 2'h0)
    else $error("reserved bit holds a one");
  fixedCode_a: assert property (
    convValid && s.dcfg.fixedPatternOutput |=>
      dataValid && dataOut[15:4] == 12'ha5a)
    else $error("fixed pattern not returned");
  channelTag_a: assert property (
    convValid && s.dcfg.tagSelect == 2'h1 |=>
      dataOut[3:0] == $past(convChannel))
    else $error("channel id not appended");
  writeBlocked_a: assert property (
    isWrite && s.checkErr && frAddr == 8'h02 |=> $stable(s.dcfg))
    else $error("write passed while input check error set");
  brownClear_a: assert property (
    isWrite && frAddr == 8'h00 && frData[0] |=> !s.brownout)
    else $error("brownout flag not cleared by write of one");
  calStart_a: assert property (
    isWrite && frAddr == 8'h01 && frData[1] && !frData[0] &&
      !s.gen.calibrate |=> calStart && s.gen.calibrate)
    else $error("calibration request did not start calibration");
  gpioPass_a: assert property (
    !s.gen.forceAnalogChannels |=>
      softResetPulse || channelIsGpio == $past(pinGpioConfig))
    else $error("gpio configuration not passed through");
endmodule

//--- verif/adcgdc_host.sv
// host-side serial master model that frames register traffic
`timescale 1ns/1ns
module adcgdc_host (
  output logic sclk,
  output logic csN,
  output logic mosi,
  input wire logic miso
);
  logic [1:0] fmt = 2'h0;
  logic chkOn = 1'b0;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // one frame; clock is set to its idle level before select, then toggles only while selected
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] op, input logic [7:0] addr,
      input logic [7:0] data, input logic bad, output logic [31:0] rx);
    logic [31:0] w;
    int n;
    n = chkOn ? 32 : 24;
    w = {op, addr, data, crc8({op, addr, data}) ^ {7'h00, bad}};
    if (!chkOn) w = w >> 8;
    rx = 32'h0;
    sclk = fmt[1];
    #8;
    csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (!fmt[0]) mosi = w[i];
      #8;
      // miso is read just before the edge so its own update cannot race
      if (!fmt[0]) rx = {rx[30:0], miso};
      sclk = ~sclk;
      if (fmt[0]) mosi = w[i];
      #7;
      if (fmt[0]) rx = {rx[30:0], miso};
      sclk = ~sclk;
    end
    #8;
    csN = 1'b1;
    // released data line must not keep showing the last bit
    mosi = ~mosi;
    if (!chkOn) rx = rx << 8;
    #600;
  endtask
endmodule

//--- verif/test_adc_general_data_config.sv
// self-checking bench of the configuration bank and its serial port
`timescale 1ns/1ns
module test_adc_general_data_config;
  logic clk;
  logic rst;
  logic convValid;
  logic [11:0] convData;
  logic [3:0] convChannel;
  logic [3:0] convFlags;
  logic calDone;
  logic [7:0] pinGpioConfig;
  logic sclk, csN, mosi, miso, misoOe, checkEnable, windowCompEnable;
  logic calStart, softResetPulse, dataValid;
  logic [7:0] channelIsGpio;
  logic [11:0] statMin, statMax, statRecent;
  logic [15:0] dataOut;
  logic [7:0] v;
  int errCount = 0;
  int checked = 0;
  int calSeen = 0;
  int rstSeen = 0;

  adcgdc_top adcgdc_top_inst (.clk(clk), .rst(rst), .sclk(sclk),
    .csN(csN), .mosi(mosi), .convValid(convValid), .convData(convData),
    .convChannel(convChannel), .convFlags(convFlags), .calDone(calDone),
    .pinGpioConfig(pinGpioConfig), .miso(miso), .misoOe(misoOe),
    .checkEnable(checkEnable), .windowCompEnable(windowCompEnable),
    .channelIsGpio(channelIsGpio), .calStart(calStart),
    .softResetPulse(softResetPulse), .statMin(statMin), .statMax(statMax),
    .statRecent(statRecent), .dataOut(dataOut), .dataValid(dataValid));
  adcgdc_host adcgdc_host_inst (.sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (calStart === 1'b1) calSeen++;
    if (softResetPulse === 1'b1) rstSeen++;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic bad);
    logic [31:0] r;
    adcgdc_host_inst.xfer(8'h08, a, d, bad, r);
  endtask

  // answer arrives in the following frame, so a nop frame fetches it
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    logic [31:0] r;
    adcgdc_host_inst.xfer(8'h10, a, 8'h00, 1'b0, r);
    adcgdc_host_inst.xfer(8'h00, 8'h00, 8'h00, 1'b0, r);
    b = r[31:24];
    if (adcgdc_host_inst.chkOn) begin
      chk(r[23:16], adcgdc_host_inst.crc8({8'h00, a, b}));
    end
  endtask

  task automatic conv(input logic [11:0] d, input logic [15:0] exp);
    @(posedge clk);
    convValid <= 1'b1;
    convData <= d;
    convChannel <= 4'h5;
    convFlags <= 4'h9;
    @(posedge clk);
    convValid <= 1'b0;
    @(negedge clk);
    chk(dataValid, 1'b1);
    chk(dataOut, exp);
  endtask

  task automatic done(input string name);
    $display("test %s done, mismatches so far %0d", name, errCount);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(misoOe, 1'b0);
    rd(8'h01, v); chk(v, 8'h00);
    rd(8'h02, v); chk(v, 8'h00);
    rd(8'h00, v); chk(v, 8'h81);
    done("reset");
  endtask

  task automatic t_general;
    chk(channelIsGpio, 8'ha5);
    wr(8'h01, 8'hbe, 1'b0);
    chk(windowCompEnable, 1'b1);
    chk(channelIsGpio, 8'h00);
    chk(calSeen, 1);
    rd(8'h01, v); chk(v, 8'h36);
    @(posedge clk);
    calDone <= 1'b1;
    @(posedge clk);
    calDone <= 1'b0;
    for (int i = 0; i < 4 && v[1]; i++) rd(8'h01, v);
    chk(v, 8'h34);
    wr(8'h01, 8'h00, 1'b0);
    chk(windowCompEnable, 1'b0);
    chk(channelIsGpio, 8'ha5);
    done("general");
  endtask

  task automatic t_stats;
    wr(8'h01, 8'h20, 1'b0);
    conv(12'h300, 16'h3000);
    conv(12'h100, 16'h1000);
    conv(12'h200, 16'h2000);
    chk(statMin, 12'h100);
    chk(statMax, 12'h300);
    chk(statRecent, 12'h200);
    wr(8'h01, 8'h00, 1'b0);
    conv(12'hfff, 16'hfff0);
    chk(statMin, 12'h100);
    chk(statMax, 12'h300);
    chk(statRecent, 12'h200);
    wr(8'h01, 8'h20, 1'b0);
    chk(statMin, 12'hfff);
    chk(statMax, 12'h000);
    chk(statRecent, 12'h000);
    wr(8'h01, 8'h00, 1'b0);
    done("stats");
  endtask

  task automatic t_data;
    logic [3:0] tg;
    wr(8'h02, 8'hfc, 1'b0);
    rd(8'h02, v); chk(v, 8'hb0);
    conv(12'h321, 16'ha5a0);
    for (int t = 0; t < 3; t++) begin
      wr(8'h02, {2'h0, t[1:0], 4'h0}, 1'b0);
      tg = (t == 1) ? 4'h5 : (t == 2) ? 4'h9 : 4'h0;
      conv(12'h3c0 + 12'(t), {12'h3c0 + 12'(t), tg});
    end
    done("data");
  endtask

  task automatic t_format;
    for (int f = 1; f < 5; f++) begin
      wr(8'h02, {6'h00, 2'(f)}, 1'b0);
      wr(8'hff, 8'h00, 1'b0);
      adcgdc_host_inst.fmt = 2'(f);
      rd(8'h02, v); chk(v, 8'(f & 3));
    end
    done("format");
  endtask

  task automatic t_check;
    wr(8'h01, 8'h40, 1'b0);
    adcgdc_host_inst.chkOn = 1'b1;
    chk(checkEnable, 1'b1);
    rd(8'h01, v); chk(v, 8'h40);
    wr(8'h02, 8'h01, 1'b1);
    rd(8'h00, v); chk(v, 8'h83);
    wr(8'h02, 8'h01, 1'b0);
    rd(8'h02, v); chk(v, 8'h00);
    wr(8'h01, 8'h44, 1'b0);
    rd(8'h01, v); chk(v, 8'h44);
    wr(8'h00, 8'h03, 1'b0);
    rd(8'h00, v); chk(v, 8'h80);
    wr(8'h02, 8'h20, 1'b0);
    rd(8'h02, v); chk(v, 8'h20);
    done("check");
  endtask

  task automatic t_softreset;
    wr(8'h01, 8'h7f, 1'b0);
    adcgdc_host_inst.chkOn = 1'b0;
    chk(rstSeen, 1);
    chk(checkEnable, 1'b0);
    rd(8'h01, v); chk(v, 8'h00);
    rd(8'h02, v); chk(v, 8'h00);
    rd(8'h00, v); chk(v, 8'h81);
    done("softreset");
  endtask

  initial begin
    rst = 1'b1;
    convValid = 1'b0;
    convData = 12'h000;
    convChannel = 4'h0;
    convFlags = 4'h0;
    calDone = 1'b0;
    pinGpioConfig = 8'ha5;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_general;
    t_stats;
    t_data;
    t_format;
    t_check;
    t_softreset;
    tally_and_finish;
  end

  // whole run needs roughly 70 us of frames
  initial begin
    #1000000;
    errCount++;
    tally_and_finish;
  end
endmodule
